// [ipa_pkg.sv]
// constants, register map and field layout of the interrupt priority arbiter
// Functional notes
// - three-bit level in low bits of nibble
// - nibble top bit ignores writes, reads zero
// - level 0 lowest, level 7 highest
// - source number breaks ties at equal level
// - number 0 first, number 53 last
// - source number itself is the tie rank
// - vector number is source number plus eight
// - numbers 0 to 18 are fixed peripheral sources
// - higher level beats better natural rank
// - level zero source is never selected
// - flag sets regardless of enable; enabled compete
// - request only above current core level
// - nesting disable blocks new while in service, freezes core level to software writes
package ipa_pkg;

  // sizes
  localparam int NUM_SRC = 54;
  localparam int LVL_W = 3;
  localparam int NIB_W = 4;
  localparam int NUM_W = 6;
  localparam int VEC_W = 6;
  localparam int IPL_W = 4;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 6;
  localparam int FLAG_BITS = 64;
  localparam int FLAG_WORDS = 4;
  localparam int NIB_PER_WORD = 4;
  localparam int PRIO_WORDS = 14;
  localparam int PRIO_SLOTS = 56;
  localparam int NUM_PINS = 4;
  localparam int EVT_W = 3;

  //////////////////////////////////////////////////////////////////////////////
  // source map
  localparam logic [VEC_W-1:0] VEC_BASE = 6'h08;
  localparam logic [FLAG_BITS-1:0] IMPL_MASK = 64'h0000_0990_0087_FFFF;
  localparam int PIN_NUM [NUM_PINS] = '{0, 16, 23, 36};
  localparam logic [LVL_W-1:0] LVL_DISABLED = 3'h0;

  //////////////////////////////////////////////////////////////////////////////
  // register word addresses
  localparam logic [ADDR_W-1:0] OFS_FLAG = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_PRIO = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h16;
  localparam logic [ADDR_W-1:0] OFS_CORE_LVL = 6'h17;
  localparam logic [ADDR_W-1:0] OFS_EVT_STAT = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 6'h19;
  localparam logic [ADDR_W-1:0] OFS_WINNER = 6'h1a;

  // field positions
  localparam int CTRL_NEST_BIT = 0;
  localparam int WIN_LVL_LSB = 0;
  localparam int WIN_VEC_LSB = 4;
  localparam int WIN_VALID_BIT = 15;
  localparam int EVT_TAKEN = 0;
  localparam int EVT_BLOCKED = 1;
  localparam int EVT_IGNORED = 2;

endpackage

// [ipa_arb_if.sv]
// candidate and winner signals between the register core and the arbiter
`timescale 1ns/1ps
interface ipa_arb_if #(
  parameter int N = ipa_pkg::NUM_SRC
);
  logic [N-1:0] cand;
  logic [N-1:0][ipa_pkg::LVL_W-1:0] lvl;
  logic win_valid;
  logic [ipa_pkg::NUM_W-1:0] win_num;
  logic [ipa_pkg::LVL_W-1:0] win_lvl;

  modport solver (
    input cand,
    input lvl,
    output win_valid,
    output win_num,
    output win_lvl
  );

  modport user (
    output cand,
    output lvl,
    input win_valid,
    input win_num,
    input win_lvl
  );
endinterface // ipa_arb_if

// [ipa_arbiter.sv]
// combinational level-then-number arbiter over all candidates
`timescale 1ns/1ps
module ipa_arbiter #(
  parameter int N = ipa_pkg::NUM_SRC
) (
  // candidates in, winner out
  ipa_arb_if.solver arb
);
  import ipa_pkg::*;

  logic best_valid;
  logic [NUM_W-1:0] best_num;
  logic [LVL_W-1:0] best_lvl;

  // scan upward; strict compare keeps the lower number on a tie
  always_comb begin
    best_valid = 1'b0;
    best_num = '0;
    best_lvl = '0;
    for (int i = 0; i < N; i++) begin
      if (arb.cand[i] && arb.lvl[i] != LVL_DISABLED) begin
        if (!best_valid || arb.lvl[i] > best_lvl) begin
          best_valid = 1'b1;
          best_num = NUM_W'(i);
          best_lvl = arb.lvl[i];
        end
      end
    end
  end

  assign arb.win_valid = best_valid;
  assign arb.win_num = best_num;
  assign arb.win_lvl = best_lvl;

endmodule // ipa_arbiter

// [ipa_top.sv]
// interrupt priority arbiter: flags, enables, levels, core request and bus slave
`timescale 1ns/1ps
module ipa_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register port
  input wire logic [ipa_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ipa_pkg::DATA_W-1:0] reg_wr_data,
  input wire logic reg_wr_stb,
  input wire logic reg_rd_stb,
  output logic [ipa_pkg::DATA_W-1:0] reg_rd_data,
  // interrupt sources
  input wire logic [ipa_pkg::NUM_SRC-1:0] periph_evt,
  input wire logic [ipa_pkg::NUM_PINS-1:0] ext_pin,
  // processor core side
  output logic core_irq_req,
  output logic [ipa_pkg::VEC_W-1:0] core_irq_vector,
  output logic [ipa_pkg::LVL_W-1:0] core_irq_level,
  input wire logic core_ack,
  input wire logic core_return,
  input wire logic [ipa_pkg::IPL_W-1:0] core_restore_level,
  output logic [ipa_pkg::IPL_W-1:0] core_priority_level,
  output logic nesting_disable,
  // block interrupt
  output logic irq_out
);
  import ipa_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [FLAG_BITS-1:0] flag;
    logic [FLAG_BITS-1:0] enable;
    logic [PRIO_SLOTS-1:0][LVL_W-1:0] level;
    logic nest_dis;
    logic in_service;
    logic [IPL_W-1:0] core_lvl;
    logic [NUM_PINS-1:0] sync1;
    logic [NUM_PINS-1:0] sync2;
    logic [NUM_PINS-1:0] sync3;
    logic [NUM_PINS-1:0] pin_lvl;
    logic [EVT_W-1:0] evt_stat;
    logic [EVT_W-1:0] evt_mask;
    logic [DATA_W-1:0] rd_data;
    logic req;
    logic [VEC_W-1:0] vector;
    logic [LVL_W-1:0] req_lvl;
  } ipa_top_state_s;

  ipa_top_state_s s_r;
  ipa_top_state_s s_nxt;

  logic [NUM_PINS-1:0] pin_rise;
  logic [FLAG_BITS-1:0] pin_set;
  logic [FLAG_BITS-1:0] set_vec;
  logic [FLAG_BITS-1:0] live_mask;
  logic beats_core;
  logic nest_block;
  logic go;
  logic taken;
  logic [EVT_W-1:0] evt;
  logic [EVT_W-1:0] evt_clr;
  logic [FLAG_BITS-1:0] ign_vec;
  logic [FLAG_WORDS-1:0] hit_flag;
  logic [FLAG_WORDS-1:0] hit_enable;
  logic [PRIO_WORDS-1:0] hit_prio;
  logic hit_ctrl;
  logic hit_core_lvl;
  logic hit_evt_stat;
  logic hit_evt_mask;
  logic hit_winner;
  logic [DATA_W-1:0] rd_flag_word;
  logic [DATA_W-1:0] rd_enable_word;
  logic [DATA_W-1:0] rd_prio_word;
  logic [DATA_W-1:0] rd_ctrl_word;
  logic [DATA_W-1:0] rd_core_lvl_word;
  logic [DATA_W-1:0] rd_stat_word;
  logic [DATA_W-1:0] rd_mask_word;
  logic [DATA_W-1:0] rd_winner_word;
  logic [DATA_W-1:0] rd_word;

  //////////////////////////////////////////////////////////////////////////////
  // arbiter

  ipa_arb_if #(.N(NUM_SRC)) arb ();

  // reserved numbers never compete, even if software set their flag
  assign arb.cand = s_r.flag[NUM_SRC-1:0] & s_r.enable[NUM_SRC-1:0]
                    & IMPL_MASK[NUM_SRC-1:0];
  assign arb.lvl = s_r.level[NUM_SRC-1:0];

  ipa_arbiter #(.N(NUM_SRC)) u_arb (
    .arb(arb)
  );

  //////////////////////////////////////////////////////////////////////////////
  // pin edges and flag sources

  // glitch filter: second and third stage must agree before the level moves
  always_comb begin
    pin_rise = '0;
    for (int p = 0; p < NUM_PINS; p++) begin
      if (s_r.sync2[p] == s_r.sync3[p]) begin
        pin_rise[p] = s_r.sync3[p] & ~s_r.pin_lvl[p];
      end
    end
  end

  always_comb begin
    pin_set = '0;
    for (int p = 0; p < NUM_PINS; p++) begin
      pin_set[PIN_NUM[p]] = pin_rise[p];
    end
  end

  // enable plays no part in setting a flag
  assign set_vec = (FLAG_BITS'(periph_evt) | pin_set) & IMPL_MASK;

  // sources that can actually win: enabled and given a nonzero level
  always_comb begin
    live_mask = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      live_mask[i] = s_r.enable[i] & (s_r.level[i] != LVL_DISABLED);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // core request

  assign beats_core = arb.win_valid
                      && ({1'b0, arb.win_lvl} > s_r.core_lvl);
  assign nest_block = s_r.nest_dis && s_r.in_service;
  assign go = beats_core && !nest_block;
  assign taken = core_ack && s_r.req;

  // a flag raised while its source cannot win is worth telling software about
  assign ign_vec = set_vec & ~live_mask;

  always_comb begin
    evt = '0;
    evt[EVT_TAKEN] = taken;
    evt[EVT_BLOCKED] = beats_core && nest_block;
    evt[EVT_IGNORED] = |ign_vec;
  end

  assign evt_clr = (reg_wr_stb && hit_evt_stat) ? reg_wr_data[EVT_W-1:0] : '0;

  //////////////////////////////////////////////////////////////////////////////
  // address decode

  // one hit per word; the read words below are built from them
  always_comb begin
    hit_flag = '0;
    hit_enable = '0;
    hit_prio = '0;
    for (int w = 0; w < FLAG_WORDS; w++) begin
      hit_flag[w] = reg_addr == OFS_FLAG + ADDR_W'(w);
      hit_enable[w] = reg_addr == OFS_ENABLE + ADDR_W'(w);
    end
    for (int w = 0; w < PRIO_WORDS; w++) begin
      hit_prio[w] = reg_addr == OFS_PRIO + ADDR_W'(w);
    end
  end

  assign hit_ctrl = reg_addr == OFS_CTRL;
  assign hit_core_lvl = reg_addr == OFS_CORE_LVL;
  assign hit_evt_stat = reg_addr == OFS_EVT_STAT;
  assign hit_evt_mask = reg_addr == OFS_EVT_MASK;
  assign hit_winner = reg_addr == OFS_WINNER;

  //////////////////////////////////////////////////////////////////////////////
  // read words

  // and-or mux: each word stays zero unless its own address hits
  always_comb begin
    rd_flag_word = '0;
    for (int w = 0; w < FLAG_WORDS; w++) begin
      if (hit_flag[w]) begin
        rd_flag_word = s_r.flag[w*DATA_W +: DATA_W];
      end
    end
  end

  always_comb begin
    rd_enable_word = '0;
    for (int w = 0; w < FLAG_WORDS; w++) begin
      if (hit_enable[w]) begin
        rd_enable_word = s_r.enable[w*DATA_W +: DATA_W];
      end
    end
  end

  // the top bit of every nibble stays zero
  always_comb begin
    rd_prio_word = '0;
    for (int w = 0; w < PRIO_WORDS; w++) begin
      if (hit_prio[w]) begin
        for (int n = 0; n < NIB_PER_WORD; n++) begin
          rd_prio_word[n*NIB_W +: LVL_W] = s_r.level[w*NIB_PER_WORD+n];
        end
      end
    end
  end

  always_comb begin
    rd_ctrl_word = '0;
    if (hit_ctrl) begin
      rd_ctrl_word[CTRL_NEST_BIT] = s_r.nest_dis;
    end
  end

  always_comb begin
    rd_core_lvl_word = '0;
    if (hit_core_lvl) begin
      rd_core_lvl_word[IPL_W-1:0] = s_r.core_lvl;
    end
  end

  always_comb begin
    rd_stat_word = '0;
    if (hit_evt_stat) begin
      rd_stat_word[EVT_W-1:0] = s_r.evt_stat;
    end
  end

  always_comb begin
    rd_mask_word = '0;
    if (hit_evt_mask) begin
      rd_mask_word[EVT_W-1:0] = s_r.evt_mask;
    end
  end

  always_comb begin
    rd_winner_word = '0;
    if (hit_winner) begin
      rd_winner_word[WIN_LVL_LSB +: LVL_W] = s_r.req_lvl;
      rd_winner_word[WIN_VEC_LSB +: VEC_W] = s_r.vector;
      rd_winner_word[WIN_VALID_BIT] = s_r.req;
    end
  end

  assign rd_word = rd_flag_word | rd_enable_word | rd_prio_word | rd_ctrl_word
                   | rd_core_lvl_word | rd_stat_word | rd_mask_word | rd_winner_word;

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_nxt = s_r;

    // three-stage synchroniser; first stage feeds only the second
    s_nxt.sync1 = ext_pin;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.sync3 = s_r.sync2;
    for (int p = 0; p < NUM_PINS; p++) begin
      if (s_r.sync2[p] == s_r.sync3[p]) begin
        s_nxt.pin_lvl[p] = s_r.sync3[p];
      end
    end

    // software writes
    for (int w = 0; w < FLAG_WORDS; w++) begin
      if (reg_wr_stb && reg_addr == OFS_FLAG + ADDR_W'(w)) begin
        s_nxt.flag[w*DATA_W +: DATA_W] = reg_wr_data;
      end
      if (reg_wr_stb && reg_addr == OFS_ENABLE + ADDR_W'(w)) begin
        s_nxt.enable[w*DATA_W +: DATA_W] = reg_wr_data;
      end
    end

    for (int w = 0; w < PRIO_WORDS; w++) begin
      if (reg_wr_stb && reg_addr == OFS_PRIO + ADDR_W'(w)) begin
        for (int n = 0; n < NIB_PER_WORD; n++) begin
          // top bit of each nibble is dropped here
          s_nxt.level[w*NIB_PER_WORD+n] = reg_wr_data[n*NIB_W +: LVL_W];
        end
      end
    end

    if (reg_wr_stb && reg_addr == OFS_CTRL) begin
      s_nxt.nest_dis = reg_wr_data[CTRL_NEST_BIT];
    end

    // core level is frozen to software while nesting is off
    if (reg_wr_stb && reg_addr == OFS_CORE_LVL && !s_r.nest_dis) begin
      s_nxt.core_lvl = reg_wr_data[IPL_W-1:0];
    end

    if (reg_wr_stb && reg_addr == OFS_EVT_MASK) begin
      s_nxt.evt_mask = reg_wr_data[EVT_W-1:0];
    end

    // a hardware event in the same cycle as a clear survives
    s_nxt.flag = (s_nxt.flag | set_vec) & IMPL_MASK;
    s_nxt.enable = s_nxt.enable & IMPL_MASK;
    s_nxt.evt_stat = (s_r.evt_stat & ~evt_clr) | evt;

    // core handshake overrides a software write of the level
    if (taken) begin
      s_nxt.in_service = 1'b1;
      s_nxt.core_lvl = {1'b0, s_r.req_lvl};
    end else if (core_return) begin
      s_nxt.in_service = 1'b0;
      s_nxt.core_lvl = core_restore_level;
    end

    // fresh winner every cycle; drop the request right after it is taken
    s_nxt.req = go && !taken;
    s_nxt.vector = arb.win_valid ? arb.win_num + VEC_BASE : '0;
    s_nxt.req_lvl = arb.win_valid ? arb.win_lvl : '0;

    // read data stands for one cycle only
    s_nxt.rd_data = reg_rd_stb ? rd_word : '0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rd_data = s_r.rd_data;
  assign core_irq_req = s_r.req;
  assign core_irq_vector = s_r.vector;
  assign core_irq_level = s_r.req_lvl;
  assign core_priority_level = s_r.core_lvl;
  assign nesting_disable = s_r.nest_dis;
  assign irq_out = |(s_r.evt_stat & s_r.evt_mask);

endmodule // ipa_top

// [ipa_core_model.sv]
// processor core model: takes a request, serves it, then returns
`timescale 1ns/1ps
module ipa_core_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // bench control and core port
  input wire logic take_en,
  input wire logic core_irq_req,
  output logic core_ack,
  output logic core_return,
  output logic [ipa_pkg::IPL_W-1:0] core_restore_level
);
  import ipa_pkg::*;
  logic [2:0] cnt_r;
  // service always ends by dropping back to level zero
  assign core_restore_level = 4'h0;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 3'h0;
      core_ack <= 1'b0;
      core_return <= 1'b0;
    end else begin
      core_return <= cnt_r == 3'h1;
      core_ack <= take_en && core_irq_req && cnt_r == 3'h0;
      if (take_en && core_irq_req && cnt_r == 3'h0) begin
        cnt_r <= 3'h5;
      end else if (cnt_r != 3'h0) begin
        cnt_r <= cnt_r - 3'h1;
      end
    end
  end
endmodule // ipa_core_model

// [ipa_top_chk.sv]
// assertions on the core side ports of the interrupt priority arbiter
`timescale 1ns/1ps
module ipa_top_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register port
  input wire logic [ipa_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr_stb,
  // core side
  input wire logic core_irq_req,
  input wire logic [ipa_pkg::VEC_W-1:0] core_irq_vector,
  input wire logic [ipa_pkg::LVL_W-1:0] core_irq_level,
  input wire logic core_ack,
  input wire logic core_return,
  input wire logic [ipa_pkg::IPL_W-1:0] core_priority_level,
  input wire logic nesting_disable
);
  import ipa_pkg::*;
  logic svc_r;
  // ack wins over return, as in the block
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      svc_r <= 1'b0;
    end else if (core_ack && core_irq_req) begin
      svc_r <= 1'b1;
    end else if (core_return) begin
      svc_r <= 1'b0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_vec_range: assert property (core_irq_level != 3'h0 |->
    core_irq_vector >= 6'h08 && core_irq_vector <= 6'h3d) else $error("vector out of range");
  a_vec_none: assert property (core_irq_level == 3'h0 |-> core_irq_vector == 6'h00)
    else $error("vector without winner");
  a_lvl_nonzero: assert property (core_irq_req |-> core_irq_level != 3'h0)
    else $error("request at level zero");
  a_above_core: assert property (core_irq_req && $stable(core_priority_level) |->
    {1'b0, core_irq_level} > core_priority_level) else $error("request not above core");
  a_ack_loads: assert property (core_ack && core_irq_req |=>
    core_priority_level == {1'b0, $past(core_irq_level)}) else $error("core level not loaded");
  a_ack_drops: assert property (core_ack && core_irq_req |=> !core_irq_req)
    else $error("request stays after ack");
  a_nest_block: assert property (svc_r && $past(svc_r) && nesting_disable &&
    $past(nesting_disable) |-> !core_irq_req) else $error("nested request");
  a_nest_freeze: assert property (nesting_disable && $past(nesting_disable) &&
    $past(reg_wr_stb) && $past(reg_addr) == OFS_CORE_LVL && !$past(core_ack) &&
    !$past(core_return) |-> $stable(core_priority_level)) else $error("core level written");
endmodule // ipa_top_chk
bind ipa_top ipa_top_chk chk (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wr_stb(reg_wr_stb), .core_irq_req(core_irq_req), .core_irq_vector(core_irq_vector),
  .core_irq_level(core_irq_level), .core_ack(core_ack), .core_return(core_return),
  .core_priority_level(core_priority_level), .nesting_disable(nesting_disable));

// [ipa_top_tb_top.sv]
// self-checking bench of the interrupt priority arbiter with a core model
`timescale 1ns/1ps
module ipa_top_tb_top;
  import ipa_pkg::*;
  logic core_clk = 1'b0;
  logic nrst, reg_wr_stb, reg_rd_stb, core_ack, core_return, core_irq_req, irq_out;
  logic nesting_disable, take_en, ns;
  logic [5:0] reg_addr, core_irq_vector;
  logic [15:0] reg_wr_data, reg_rd_data;
  logic [53:0] periph_evt;
  logic [3:0] ext_pin, core_restore_level, core_priority_level, cpl;
  logic [2:0] core_irq_level;
  logic [2:0] ev = 3'h0;
  logic [63:0] fl, en, r64;
  logic [2:0] pr [56];
  logic [31:0] seed = 32'hf6e1_bece;
  int n_errors, n_compared, b;
  always #2 core_clk = ~core_clk;
  ipa_top dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb),
    .reg_rd_data(reg_rd_data), .periph_evt(periph_evt), .ext_pin(ext_pin),
    .core_irq_req(core_irq_req), .core_irq_vector(core_irq_vector),
    .core_irq_level(core_irq_level), .core_ack(core_ack), .core_return(core_return),
    .core_restore_level(core_restore_level), .core_priority_level(core_priority_level),
    .nesting_disable(nesting_disable), .irq_out(irq_out));
  ipa_core_model core (.core_clk(core_clk), .nrst(nrst), .take_en(take_en),
    .core_irq_req(core_irq_req), .core_ack(core_ack), .core_return(core_return),
    .core_restore_level(core_restore_level));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] er(int a);
    int p;
    p = (a - 8) * 4;
    if (a < 4) return fl[a*16+:16];
    if (a < 8) return en[(a-4)*16+:16];
    if (a < 22) return {1'b0, pr[p+3], 1'b0, pr[p+2], 1'b0, pr[p+1], 1'b0, pr[p]};
    if (a == 22) return {15'h0, ns};
    if (a == 23) return {12'h000, cpl};
    if (a == 24) return {13'h0000, ev};
    return 16'h0000;
  endfunction
  // lowest number kept on equal level
  function automatic int win();
    int w;
    w = -1;
    for (int i = 0; i < 54; i++)
      if (fl[i] && en[i] && pr[i] != 3'h0 && (w < 0 || pr[i] > pr[w])) w = i;
    return w;
  endfunction
  task automatic ck(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      n_errors++;
    end
  endtask
  task automatic wr(input int a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a[5:0];
    reg_wr_data <= d;
    reg_wr_stb <= 1'b1;
    @(posedge core_clk);
    reg_wr_stb <= 1'b0;
    if (a < 4) fl[a*16+:16] = d & IMPL_MASK[a*16+:16];
    else if (a < 8) en[(a-4)*16+:16] = d & IMPL_MASK[(a-4)*16+:16];
    else if (a < 22) for (int n = 0; n < 4; n++) pr[(a-8)*4+n] = d[n*4+:3];
    else if (a == 22) ns = d[0];
    else if (a == 23 && !ns) cpl = d[3:0];
    else if (a == 24) ev = ev & ~d[2:0];
  endtask
  task automatic rd(input int a);
    @(posedge core_clk);
    reg_addr <= a[5:0];
    reg_rd_stb <= 1'b1;
    @(posedge core_clk);
    reg_rd_stb <= 1'b0;
    #1;
    ck(reg_rd_data, er(a));
  endtask
  task automatic sweep();
    for (int a = 0; a < 24; a++) rd(a);
    rd(31);
  endtask
  task automatic results();
    $display("errors=%0d compared=%0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    results();
  end
  initial begin
    {nrst, reg_wr_stb, reg_rd_stb, take_en, ns, reg_addr, reg_wr_data} = '0;
    {periph_evt, ext_pin, cpl, fl, en} = '0;
    for (int i = 0; i < 56; i++) pr[i] = 3'h0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    sweep();
    for (int w = 8; w < 22; w++) wr(w, 16'(xs()));
    r64 = {xs(), xs()};
    periph_evt <= r64[53:0];
    ext_pin <= 4'h2;
    @(posedge core_clk);
    periph_evt <= '0;
    fl = fl | (r64 & IMPL_MASK) | 64'h0000_0000_0001_0000;
    ev[2] = 1'b1;
    repeat (8) @(posedge core_clk);
    sweep();
    // random flags, enables and levels give plenty of ties
    repeat (12) begin
      for (int w = 0; w < 22; w++) wr(w, 16'(xs()));
      repeat (2) @(posedge core_clk);
      #1;
      b = win();
      ck(core_irq_vector, b < 0 ? 16'h0000 : 16'(b + 8));
      ck(core_irq_level, b < 0 ? 3'h0 : pr[b]);
      ck(core_irq_req, b >= 0);
    end
    for (int w = 0; w < 8; w++) wr(w, w == 4 ? 16'h0008 : 16'h0000);
    wr(8, 16'h5000);
    periph_evt <= 54'h8;
    @(posedge core_clk);
    periph_evt <= '0;
    fl[3] = 1'b1;
    for (int c = 4; c < 6; c++) begin
      wr(23, c[15:0]);
      repeat (2) @(posedge core_clk);
      #1;
      ck(core_irq_req, c < 5);
    end
    wr(23, 16'h0000);
    wr(22, 16'h0001);
    wr(25, 16'h0001);
    take_en <= 1'b1;
    for (int i = 0; i < 20 && core_ack !== 1'b1; i++) @(posedge core_clk) #1;
    take_en <= 1'b0;
    // raise the served source above the core level while nesting is off
    wr(8, 16'h7000);
    ev[1:0] = 2'b11;
    repeat (2) @(posedge core_clk);
    #1;
    ck(core_priority_level, 16'h0005);
    ck(core_irq_req, 1'b0);
    ck(nesting_disable, ns);
    ck(irq_out, 1'b1);
    repeat (10) @(posedge core_clk);
    cpl = 4'h0;
    wr(23, 16'h0002);
    rd(23);
    wr(25, 16'h0000);
    #1;
    ck(irq_out, 1'b0);
    wr(25, 16'h0001);
    #1;
    ck(irq_out, 1'b1);
    wr(24, 16'h0001);
    #1;
    ck(irq_out, 1'b0);
    rd(24);
    results();
  end
endmodule // ipa_top_tb_top
